// ### wdr_top.sv
/*
  Watchdog timer with key-protected control, reset-source flags,
  external reset pin selection and power-on release delay.
  Assumes a CPU on REF_CLK supplies instruction pulses and a plain
  register port; the RC clock and reset pin are asynchronous inputs.
*/
// The placing of the registers and the plain strobed port are this design's own decisions.
// What this block does
// - Counter ticks only from low-speed RC clock
// - Select field picks 2^8 to 2^18 period
// - Key 10101 disables, 01010 enables
// - Other key values reset after fixed delay
// - Illegal key reset sets flag bit 0
// - Hardware sets flag; software clears by zero
// - Control register resets to 01010011
// - Running overflow resets device, sets timeout flag
// - Low-power overflow clears PC and SP only
// - Key reset, clear, halt, pin clear count
// - Flag register upper four bits read zero
// - Power-on reset zeroes program counter
// - Port registers power up all ones
// - Reset pin works only when selected
// - Power-on delay follows pin release
// - Low-power timeout sets timeout; power-down keeps its value
`timescale 1ns/1ns
module wdr_top (
  input  wire logic             REF_CLK,
  input  wire logic             NRST,
  input  wire logic             CE,
  input  wire wdr_pkg::wdr_bus_t BUS,
  input  wire wdr_pkg::wdr_cpu_t CPU,
  input  wire logic             LOW_SPEED_RC_CLOCK,
  input  wire logic             EXTERNAL_RESET_PIN_N,
  output logic [7:0]            RDATA,
  output logic                  DEVICE_RESET,
  output logic                  PC_SP_CLEAR,
  output logic                  TIMEOUT_FLAG,
  output logic                  POWER_DOWN_FLAG,
  output logic [7:0]            PORT_INIT
);
  import wdr_pkg::*;

  // ==========================================================
  // State
  typedef enum logic [1:0] {S_RUN, S_KEY_WAIT, S_RESET, S_START} wdr_phase_t;

  typedef struct packed {
    wdr_phase_t           phase;
    logic [7:0]           control;
    logic [7:0]           pin_sel;
    logic                 key_flag;
    logic                 pin_flag;
    logic                 timeout;
    logic                 power_down;
    logic [WDR_DLY_W-1:0] dly;
    logic [7:0]           rdata;
    logic                 dev_reset;
    logic                 pc_sp_clear;
    logic                 low_speed_rc_osc_prev;
    logic [7:0]           port_init;
  } wdr_state_t;

  wdr_state_t st;
  wdr_state_t next_st;

  logic low_speed_rc_osc_s;
  logic pin_s;
  logic tick;
  logic overflow;
  logic key_on;
  logic key_off;
  logic key_bad;
  logic pin_sel_res;
  logic pin_low;
  logic wdt_clear;
  logic [4:0] key;

  // ==========================================================
  // Input synchronisers
  wdr_sync u_sync_low_speed_rc_osc (
    .REF_CLK (REF_CLK),
    .NRST    (NRST),
    .ce      (CE),
    .d       (LOW_SPEED_RC_CLOCK),
    .q       (low_speed_rc_osc_s)
  );

  wdr_sync u_sync_pin (
    .REF_CLK (REF_CLK),
    .NRST    (NRST),
    .ce      (CE),
    .d       (!EXTERNAL_RESET_PIN_N),
    .q       (pin_s)
  );

  assign tick        = low_speed_rc_osc_s && !st.low_speed_rc_osc_prev;
  assign key         = st.control[7:WDR_KEY_LSB];
  assign key_on      = key == WDR_KEY_ON;
  assign key_off     = key == WDR_KEY_OFF;
  assign key_bad     = !key_on && !key_off;
  assign pin_sel_res = st.pin_sel == WDR_PIN_SEL_RES;
  // Pin inverted before the flops so their reset value reads as released
  assign pin_low     = pin_sel_res && pin_s;
  // Halt clears too, as do the selected pin held low and the reset phase
  assign wdt_clear   = CPU.clear_wdt || CPU.halt || pin_low ||
                       st.phase == S_RESET;

  wdr_counter u_counter (
    .REF_CLK  (REF_CLK),
    .NRST     (NRST),
    .ce       (CE),
    .tick     (tick),
    .run      (key_on && st.phase == S_RUN),
    .clear    (wdt_clear),
    .sel      (st.control[2:0]),
    .overflow (overflow)
  );

  // ==========================================================
  // Next state
  always_comb begin
    next_st = st;
    if (CE) begin
      next_st.pc_sp_clear = 1'b0;
      next_st.low_speed_rc_osc_prev   = low_speed_rc_osc_s;
      next_st.rdata     = 8'h00;
      next_st.dev_reset = st.phase == S_RESET || st.phase == S_START;

      // Register writes
      if (BUS.write) begin
        unique case (BUS.addr)
          WDR_OFS_CONTROL: next_st.control = BUS.wdata;
          WDR_OFS_FLAGS: begin
            // Writing one is ignored: only hardware sets these
            if (!BUS.wdata[WDR_FLAG_KEY_BIT]) next_st.key_flag = 1'b0;
            if (!BUS.wdata[WDR_FLAG_PIN_BIT]) next_st.pin_flag = 1'b0;
          end
          WDR_OFS_PIN_SEL: next_st.pin_sel = BUS.wdata;
          WDR_OFS_STATUS: begin
            next_st.timeout    = BUS.wdata[0];
            next_st.power_down = BUS.wdata[1];
          end
        endcase
      end

      // Register reads, one cycle later
      if (BUS.read) begin
        unique case (BUS.addr)
          WDR_OFS_CONTROL: next_st.rdata = st.control;
          WDR_OFS_FLAGS:   next_st.rdata = {4'h0, st.pin_flag, 2'b00,
                                            st.key_flag};
          WDR_OFS_PIN_SEL: next_st.rdata = st.pin_sel;
          WDR_OFS_STATUS:  next_st.rdata = {6'h00, st.power_down, st.timeout};
        endcase
      end

      if (CPU.clear_wdt) begin
        next_st.timeout    = 1'b0;
        next_st.power_down = 1'b0;
      end
      if (CPU.halt) begin
        next_st.power_down = 1'b1;
        next_st.timeout    = 1'b0;
      end

      unique case (st.phase)
        S_RUN: begin
          if (key_bad) begin
            next_st.phase = S_KEY_WAIT;
            next_st.dly   = '0;
          end else if (pin_low) begin
            next_st.phase = S_RESET;
            next_st.dly   = '0;
          end else if (overflow) begin
            next_st.timeout = 1'b1;
            if (CPU.low_power) begin
              next_st.pc_sp_clear = 1'b1;
            end else begin
              next_st.phase = S_RESET;
              next_st.dly   = '0;
            end
          end
        end
        S_KEY_WAIT: begin
          next_st.dly = st.dly + 12'h001;
          if (32'(st.dly) >= WDR_SRESET_CYC - 1) begin
            next_st.phase    = S_RESET;
            next_st.dly      = '0;
            next_st.key_flag = 1'b1;
            next_st.control  = WDR_CONTROL_RST;
          end
        end
        S_RESET: begin
          // Hold while the selected pin stays low
          if (pin_low) begin
            next_st.dly = '0;
          end else begin
            next_st.dly = st.dly + 12'h001;
            if (32'(st.dly) >= WDR_RESET_PULSE - 1) begin
              next_st.phase = S_START;
              next_st.dly   = '0;
              next_st.port_init = WDR_PORT_RST;
            end
          end
        end
        S_START: begin
          if (pin_low) begin
            next_st.phase = S_RESET;
            next_st.dly   = '0;
          end else begin
            next_st.dly = st.dly + 12'h001;
            if (32'(st.dly) >= WDR_RSTD_CYC - 1) begin
              next_st.phase = S_RUN;
            end
          end
        end
      endcase

      // Set beats a same-cycle clear
      if (st.phase == S_KEY_WAIT && 32'(st.dly) >= WDR_SRESET_CYC - 1) begin
        next_st.key_flag = 1'b1;
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      st             <= '0;
      st.phase       <= S_START;
      st.control     <= WDR_CONTROL_RST;
      st.pin_sel     <= WDR_PIN_SEL_RST;
      st.port_init   <= WDR_PORT_RST;
      st.dev_reset   <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign RDATA           = st.rdata;
  assign DEVICE_RESET    = st.dev_reset;
  assign PC_SP_CLEAR     = st.pc_sp_clear;
  assign TIMEOUT_FLAG    = st.timeout;
  assign POWER_DOWN_FLAG = st.power_down;
  assign PORT_INIT       = st.port_init;

  // ==========================================================
  // Assertions
  property p_key_reset;
    @(posedge REF_CLK) disable iff (!NRST)
      (CE && st.phase == S_RUN && key_bad) |=> st.phase == S_KEY_WAIT;
  endproperty
  a_key_reset: assert property (p_key_reset) else $error("bad key ignored");

  property p_key_flag;
    @(posedge REF_CLK) disable iff (!NRST)
      (CE && st.phase == S_KEY_WAIT && 32'(st.dly) >= WDR_SRESET_CYC - 1)
        |=> st.key_flag && st.control == WDR_CONTROL_RST;
  endproperty
  a_key_flag: assert property (p_key_flag) else $error("key reset incomplete");

  property p_flag_set;
    @(posedge REF_CLK) disable iff (!NRST)
      ($past(st.phase) == S_KEY_WAIT && st.phase == S_RESET) |-> st.key_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("key flag not set");

  property p_flag_sticky;
    @(posedge REF_CLK) disable iff (!NRST)
      (st.key_flag && !(CE && BUS.write && BUS.addr == WDR_OFS_FLAGS)) |=> st.key_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");

  property p_upper_zero;
    @(posedge REF_CLK) disable iff (!NRST)
      (CE && BUS.read && BUS.addr == WDR_OFS_FLAGS) |=> RDATA[7:4] == 4'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");

  property p_run_ovf;
    @(posedge REF_CLK) disable iff (!NRST)
      (CE && st.phase == S_RUN && !key_bad && !pin_low && overflow && !CPU.low_power)
        |=> st.phase == S_RESET ##1 DEVICE_RESET;
  endproperty
  a_run_ovf: assert property (p_run_ovf) else $error("no reset on overflow");

  property p_idle_ovf;
    @(posedge REF_CLK) disable iff (!NRST)
      (CE && st.phase == S_RUN && !key_bad && !pin_low && overflow && CPU.low_power)
        |=> PC_SP_CLEAR && TIMEOUT_FLAG && st.phase == S_RUN;
  endproperty
  a_idle_ovf: assert property (p_idle_ovf) else $error("idle overflow wrong");

  property p_pin_ignored;
    @(posedge REF_CLK) disable iff (!NRST)
      (CE && st.phase == S_RUN && !pin_sel_res && !key_bad && !overflow) |=> st.phase == S_RUN;
  endproperty
  a_pin_ignored: assert property (p_pin_ignored) else $error("pin reset unselected");

  property p_start_delay;
    @(posedge REF_CLK) disable iff (!NRST)
      (st.phase == S_START && $past(st.phase) == S_RESET) |-> DEVICE_RESET [*2];
  endproperty
  a_start_delay: assert property (p_start_delay) else $error("early release");

  c_key_reset: cover property (@(posedge REF_CLK) disable iff (!NRST) st.phase == S_KEY_WAIT);
  c_idle_ovf:  cover property (@(posedge REF_CLK) disable iff (!NRST) PC_SP_CLEAR);
  c_pin_reset: cover property (@(posedge REF_CLK) disable iff (!NRST) pin_low);
endmodule // wdr_top

// ### wdr_pkg.sv
/*
  Package for the watchdog and reset-flag block: register offsets, field
  positions, reset values, key codes, timing counts and carrier structs.
  Assumes a single 100 MHz REF_CLK domain for the register port and a
  free-running low-speed RC clock sampled as an ordinary input.
*/
package wdr_pkg;

  // ==========================================================
  // Register map
  localparam logic [1:0] WDR_OFS_CONTROL   = 2'h0;
  localparam logic [1:0] WDR_OFS_FLAGS     = 2'h1;
  localparam logic [1:0] WDR_OFS_PIN_SEL   = 2'h2;
  localparam logic [1:0] WDR_OFS_STATUS    = 2'h3;

  localparam logic [7:0] WDR_CONTROL_RST   = 8'h53;
  localparam logic [7:0] WDR_PIN_SEL_RST   = 8'h55;
  localparam logic [7:0] WDR_PIN_SEL_IO    = 8'h55;
  localparam logic [7:0] WDR_PIN_SEL_RES   = 8'haa;
  localparam logic [7:0] WDR_PORT_RST      = 8'hff;

  // ==========================================================
  // Field positions
  localparam int         WDR_KEY_LSB       = 3;
  localparam int         WDR_FLAG_KEY_BIT  = 0;
  localparam int         WDR_FLAG_PIN_BIT  = 3;
  localparam logic [4:0] WDR_KEY_OFF       = 5'h15;
  localparam logic [4:0] WDR_KEY_ON        = 5'h0a;

  // ==========================================================
  // Timing
  localparam int         WDR_CLK_MHZ       = 100;
  localparam int         WDR_SRESET_US     = 1;
  localparam int         WDR_SRESET_CYC    = WDR_SRESET_US * WDR_CLK_MHZ;
  localparam int         WDR_RSTD_US       = 20;
  localparam int         WDR_RSTD_CYC      = WDR_RSTD_US * WDR_CLK_MHZ;
  localparam int         WDR_RESET_PULSE   = 4;
  localparam int         WDR_CNT_W         = 18;
  localparam int         WDR_DLY_W         = 12;

  typedef struct packed {
    logic       write;
    logic       read;
    logic [1:0] addr;
    logic [7:0] wdata;
  } wdr_bus_t;

  typedef struct packed {
    logic clear_wdt;
    logic halt;
    logic low_power;
  } wdr_cpu_t;

endpackage

// ### wdr_sync.sv
/*
  Two-flop synchroniser for one asynchronous level.
  Assumes the clock enable applies to it like any other state.
*/
`timescale 1ns/1ns
module wdr_sync (
  input  wire logic REF_CLK,
  input  wire logic NRST,
  input  wire logic ce,
  input  wire logic d,
  output logic      q
);
  import wdr_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
  } wdr_sync_t;

  wdr_sync_t st;
  wdr_sync_t next_st;

  always_comb begin
    next_st = st;
    if (ce) begin
      next_st.s1 = d;
      next_st.s2 = st.s1;
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.s2;
endmodule // wdr_sync

// ### wdr_counter.sv
/*
  Watchdog counter ticked by synchronised low-speed clock edges.
  Assumes tick is a one-cycle pulse per low-speed clock period.
*/
`timescale 1ns/1ns
module wdr_counter (
  input  wire logic       REF_CLK,
  input  wire logic       NRST,
  input  wire logic       ce,
  input  wire logic       tick,
  input  wire logic       run,
  input  wire logic       clear,
  input  wire logic [2:0] sel,
  output logic            overflow
);
  import wdr_pkg::*;

  typedef struct packed {
    logic [WDR_CNT_W-1:0] cnt;
    logic                 ovf;
  } wdr_cnt_t;

  wdr_cnt_t             st;
  wdr_cnt_t             next_st;
  logic [WDR_CNT_W-1:0] last;

  // Terminal count is 2^n - 1 for the selected exponent
  always_comb begin
    unique case (sel)
      3'h0: last = 18'h000ff;
      3'h1: last = 18'h003ff;
      3'h2: last = 18'h00fff;
      3'h3: last = 18'h03fff;
      3'h4: last = 18'h07fff;
      3'h5: last = 18'h0ffff;
      3'h6: last = 18'h1ffff;
      3'h7: last = 18'h3ffff;
    endcase
  end

  always_comb begin
    next_st = st;
    if (ce) begin
      // Pulse holds through a frozen cycle so the top still sees it
      next_st.ovf = 1'b0;
      if (clear || !run) begin
        next_st.cnt = '0;
      end else if (tick) begin
        if (st.cnt >= last) begin
          next_st.cnt = '0;
          next_st.ovf = 1'b1;
        end else begin
          next_st.cnt = st.cnt + 18'h00001;
        end
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign overflow = st.ovf;

  property p_clear_zero;
    @(posedge REF_CLK) disable iff (!NRST)
      (ce && clear) |=> st.cnt == '0;
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("counter not cleared");
endmodule // wdr_counter

// ### test_wdr_top.sv
/*
  Self-checking bench for wdr_top: register port, watchdog periods, key
  protection, low-power timeout and external reset pin release.
  Assumes the design files are compiled first and nothing else is attached.
*/
`timescale 1ns/1ns
module test_wdr_top;
  import wdr_pkg::*;

  // ==========================================================
  // Signals
  logic       ref_clk;
  logic       nrst;
  logic       ce;
  wdr_bus_t   bus;
  wdr_cpu_t   cpu;
  logic       rc_clk;
  logic       rc_run;
  logic       pin_n;
  logic [7:0] rdata;
  logic       dev_rst;
  logic       pc_sp_clear;
  logic       timeout_flag;
  logic       power_down_flag;
  logic [7:0] port_init;
  logic [7:0] exp_q[$];
  logic       rd_pend;
  int         failures;
  int         num_checks;
  integer     seed;
  int         n;
  logic [4:0] key;
  int         per[2] = '{8, 10};

  wdr_top i_dut (
    .REF_CLK              (ref_clk),
    .NRST                 (nrst),
    .CE                   (ce),
    .BUS                  (bus),
    .CPU                  (cpu),
    .LOW_SPEED_RC_CLOCK   (rc_clk),
    .EXTERNAL_RESET_PIN_N (pin_n),
    .RDATA                (rdata),
    .DEVICE_RESET         (dev_rst),
    .PC_SP_CLEAR          (pc_sp_clear),
    .TIMEOUT_FLAG         (timeout_flag),
    .POWER_DOWN_FLAG      (power_down_flag),
    .PORT_INIT            (port_init)
  );

  always #5 ref_clk = ~ref_clk;
  // 82 ns low-speed period so its edges drift against ref_clk
  always #41 if (rc_run) rc_clk = ~rc_clk;

  // ==========================================================
  // Compare and report
  task automatic report_and_stop();
    $display("Checks %0d, failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge ref_clk) begin
    if (rd_pend) begin
      check_byte(rdata, exp_q.pop_front());
    end
    rd_pend <= bus.read;
  end

  // ==========================================================
  // Drivers
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    bus <= '0;
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    bus <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
    exp_q.push_back(exp);
    @(posedge ref_clk);
    bus <= '0;
  endtask

  task automatic pulse(input logic clr);
    @(posedge ref_clk);
    cpu <= '{clear_wdt: clr, halt: ~clr, low_power: cpu.low_power};
    @(posedge ref_clk);
    cpu <= '{clear_wdt: 1'b0, halt: 1'b0, low_power: cpu.low_power};
  endtask

  task automatic wait_sig(input bit pc, input logic val, input int lim, output int cnt);
    logic s;
    cnt = 0;
    do begin
      @(posedge ref_clk);
      cnt++;
      s = pc ? pc_sp_clear : dev_rst;
    end while (s !== val && cnt < lim);
    if (s !== val) begin
      failures++;
      $display("Error at %0t: wait ran out, got %h expected %h", $time, s, val);
      report_and_stop();
    end
  endtask

  task automatic quiet(input int cyc);
    logic seen;
    seen = 1'b0;
    repeat (cyc) begin
      @(posedge ref_clk);
      seen = seen | dev_rst;
    end
    check_bit(seen, 1'b0);
  endtask

  task automatic settle();
    wait_sig(1'b0, 1'b0, WDR_RSTD_CYC + 200, n);
    check_bit(n >= WDR_RSTD_CYC - 8 &&
              n <= WDR_RSTD_CYC + WDR_RESET_PULSE + 24, 1'b1);
  endtask

  task automatic overflow_at(input int s);
    int e;
    e = (2 ** per[s]) * 82 / 10;
    wr(WDR_OFS_CONTROL, {WDR_KEY_ON, 3'(s)});
    pulse(1'b1);
    wait_sig(1'b0, 1'b1, e + 100, n);
    check_bit(n >= e - 12 && n <= e + 24, 1'b1);
    settle();
    check_bit(timeout_flag, 1'b1);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    ce = 1'b1;
    bus = '0;
    cpu = '0;
    rc_clk = 1'b0;
    rc_run = 1'b1;
    pin_n = 1'b1;
    rd_pend = 1'b0;
    failures = 0;
    num_checks = 0;
    seed = 82564;
    repeat (16) @(posedge ref_clk);
    check_bit(dev_rst, 1'b1);
    check_byte(port_init, WDR_PORT_RST);
    nrst <= 1'b1;
    settle();
    rd(WDR_OFS_CONTROL, WDR_CONTROL_RST);
    rd(WDR_OFS_FLAGS, 8'h00);
    rd(WDR_OFS_PIN_SEL, WDR_PIN_SEL_RST);
    wr(WDR_OFS_CONTROL, {WDR_KEY_OFF, 3'h0});
    quiet(4200);
    for (int s = 0; s < 2; s++) begin
      overflow_at(s);
    end
    // No low-speed edges means no counting at all
    rc_run = 1'b0;
    wr(WDR_OFS_CONTROL, {WDR_KEY_ON, 3'h0});
    pulse(1'b1);
    quiet(4200);
    rc_run = 1'b1;
    // Refreshes spaced inside one period keep the device out of reset
    repeat (6) begin
      quiet(1000 + ($random(seed) & 511));
      pulse(1'b1);
    end
    pulse(1'b0);
    @(posedge ref_clk);
    check_bit(power_down_flag, 1'b1);
    cpu.low_power <= 1'b1;
    wait_sig(1'b1, 1'b1, 2300, n);
    @(posedge ref_clk);
    check_bit(pc_sp_clear, 1'b0);
    check_bit(dev_rst, 1'b0);
    check_bit(timeout_flag, 1'b1);
    check_bit(power_down_flag, 1'b1);
    rd(WDR_OFS_STATUS, 8'h03);
    cpu.low_power <= 1'b0;
    pulse(1'b1);
    rd(WDR_OFS_STATUS, 8'h00);
    // Clock enable low freezes a running count well past its period
    ce <= 1'b0;
    quiet(4200);
    ce <= 1'b1;
    wr(WDR_OFS_CONTROL, {WDR_KEY_OFF, 3'h0});
    // Any key other than the two codes forces a delayed reset
    repeat (3) begin
      key = 5'($random(seed));
      if (key == WDR_KEY_ON || key == WDR_KEY_OFF) begin
        key = key ^ 5'h01;
      end
      wr(WDR_OFS_CONTROL, {key, 3'h5});
      wait_sig(1'b0, 1'b1, 300, n);
      check_bit(n >= WDR_SRESET_CYC - 6 && n <= WDR_SRESET_CYC + 8, 1'b1);
      settle();
      rd(WDR_OFS_FLAGS, 8'h01);
      rd(WDR_OFS_CONTROL, WDR_CONTROL_RST);
      wr(WDR_OFS_FLAGS, 8'h00);
      wr(WDR_OFS_FLAGS, 8'hff);
      rd(WDR_OFS_FLAGS, 8'h00);
    end
    // Pin low is ignored until the pin function is selected
    pin_n <= 1'b0;
    quiet(60);
    pin_n <= 1'b1;
    wr(WDR_OFS_PIN_SEL, WDR_PIN_SEL_RES);
    rd(WDR_OFS_PIN_SEL, WDR_PIN_SEL_RES);
    pin_n <= 1'b0;
    wait_sig(1'b0, 1'b1, 20, n);
    repeat (100) @(posedge ref_clk);
    check_bit(dev_rst, 1'b1);
    pin_n <= 1'b1;
    settle();
    // Second power-on in mid-run restores the pin selection
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check_bit(dev_rst, 1'b1);
    check_byte(port_init, WDR_PORT_RST);
    nrst <= 1'b1;
    settle();
    rd(WDR_OFS_PIN_SEL, WDR_PIN_SEL_RST);
    repeat (3) @(posedge ref_clk);
    report_and_stop();
  end

endmodule // test_wdr_top
